//--- src/fpec_pkg.sv
package fpec_pkg;
   // store control register
   localparam logic [7:0] PROGRAM_STORE_CONTROL_OFS = 8'h8F;
   localparam logic [7:0] PROGRAM_STORE_CONTROL_RST = 8'h00;
   localparam int WE_BIT = 0;
   localparam int EE_BIT = 1;
   // address map
   localparam logic [15:0] MAIN_LAST = 16'h7FFF;
   localparam logic [15:0] EXTRA_BASE = 16'h8000;
   localparam logic [15:0] EXTRA_LAST = 16'h807F;
   localparam logic [15:0] LOCK_WE_ADDR = 16'h7DFE;
   localparam logic [15:0] LOCK_RD_ADDR = 16'h7DFF;
   localparam int SECTOR_SHIFT = 9;
   localparam int BLOCK_SHIFT = 12;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [3:0] PRESCALE_OFF = 4'hF;
   // timing
   localparam int CLK_MHZ = 250;
   localparam int WRITE_TIME_NS = 40000;
   localparam int ERASE_TIME_MS = 10;
   localparam int WRITE_CYCLES = (WRITE_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
   localparam int TIME_W = 22;
   // jtag operations
   typedef enum logic [1:0] {
      FPEC_JREAD = 2'h0,
      FPEC_JWRITE = 2'h1,
      FPEC_JERASE = 2'h2
   } fpec_jop_t;
   // array erase kinds
   typedef enum logic [1:0] {
      FPEC_ER_MAIN = 2'h0,
      FPEC_ER_EXTRA = 2'h1,
      FPEC_ER_MASS = 2'h2
   } fpec_erase_t;
   typedef enum logic [2:0] {
      FPEC_OP_READ = 3'h0,
      FPEC_OP_PROG = 3'h1,
      FPEC_OP_ERASE = 3'h2,
      FPEC_OP_LOCK0 = 3'h3,
      FPEC_OP_LOCK1 = 3'h4
   } fpec_op_t;
   typedef enum logic [1:0] {
      FPEC_IDLE = 2'h0,
      FPEC_RD_WAIT = 2'h1,
      FPEC_BUSY = 2'h2
   } fpec_state_t;
endpackage

//--- src/fpec_tick_gen.sv
`timescale 1ns/1ns
`default_nettype none
module fpec_tick_gen #(
   parameter int PW = 4
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // control
   input wire logic run,
   input wire logic [PW-1:0] prescale,
   // one tick every prescale+1 cycles while running
   output logic tick
);
   import fpec_pkg::*;
   logic [PW-1:0] cnt_r;
   logic [PW-1:0] cnt_nxt;

   if (PW < 1) begin
      $error("prescaler width must be positive");
   end

   assign tick = run && (cnt_r == prescale);

   always_comb begin
      cnt_nxt = cnt_r;
      if (!run || tick) begin
         cnt_nxt = '0;
      end else begin
         cnt_nxt = cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule
`default_nettype wire

//--- src/fpec_addr_check.sv
`timescale 1ns/1ns
`default_nettype none
module fpec_addr_check (
   // address under test
   input wire logic [15:0] addr,
   // lock bytes
   input wire logic [7:0] lock_rd,
   input wire logic [7:0] lock_we,
   // decode
   output logic valid,
   output logic in_extra,
   output logic in_lock_sector,
   output logic is_lock_byte,
   output logic rd_open,
   output logic we_open
);
   import fpec_pkg::*;
   logic [2:0] blk;

   assign blk = addr[BLOCK_SHIFT+2:BLOCK_SHIFT];
   assign in_extra = (addr >= EXTRA_BASE) && (addr <= EXTRA_LAST);
   assign valid = (addr <= MAIN_LAST) || in_extra;
   assign in_lock_sector = (addr[15:SECTOR_SHIFT] ==
                            LOCK_WE_ADDR[15:SECTOR_SHIFT]);
   assign is_lock_byte = (addr == LOCK_WE_ADDR) || (addr == LOCK_RD_ADDR);
   assign rd_open = in_extra || lock_rd[blk];
   assign we_open = in_extra || lock_we[blk];
endmodule
`default_nettype wire

//--- src/fpec_top.sv
// Overview of operation
// - writes only clear bits; erase gives 0xFF
// - hardware times every write and erase
// - software writes need write enable set
// - erase clears whole 512-byte main sector
// - erase plus write enable: write erases sector
// - erase mode stays until software clears it
// - 4-bit prescaler times; 1111b inhibits write and erase
// - core stalls during any program or erase
// - extra 128-byte sector at 0x8000-0x807F
// - code reads read, external writes program
// - lock bytes at 0x7DFE, 0x7DFF, 4k blocks
// - read lock zero bit blocks jtag reads
// - write lock zero bit blocks jtag writes
// - software never erases lock byte sector
// - jtag can program uninitialized device
// - one byte programmed per operation
// - only jtag mass or lock byte sector erase restores lock bits
`timescale 1ns/1ns
`default_nettype none
module fpec_top #(
   parameter int WRITE_TICKS = fpec_pkg::WRITE_CYCLES,
   parameter int ERASE_TICKS = fpec_pkg::ERASE_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // special function register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // flash timing prescaler
   input wire logic [3:0] timing_prescaler_value,
   // processor accesses
   input wire logic external_move_write,
   input wire logic code_space_read,
   input wire logic [15:0] cpu_addr,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   output logic cpu_done,
   output logic cpu_stall,
   // jtag programming port
   input wire logic jtag_req,
   input wire fpec_pkg::fpec_jop_t jtag_op,
   input wire logic [15:0] jtag_addr,
   input wire logic [7:0] jtag_wdata,
   output logic [7:0] jtag_rdata,
   output logic jtag_done,
   output logic jtag_denied,
   // flash array
   output logic [15:0] arr_addr,
   output logic arr_rd,
   input wire logic [7:0] arr_rdata,
   output logic [7:0] arr_wdata,
   output logic arr_prog,
   output logic arr_erase,
   output fpec_pkg::fpec_erase_t arr_erase_kind
);
   import fpec_pkg::*;

   if (WRITE_TICKS < 1 || ERASE_TICKS < 1) begin
      $error("tick counts too small");
   end
   if (longint'(WRITE_TICKS) >= (64'd1 << TIME_W) ||
       longint'(ERASE_TICKS) >= (64'd1 << TIME_W)) begin
      $error("tick counts exceed timer width");
   end

   // store control register
   logic [1:0] ctrl_r;
   logic [1:0] ctrl_nxt;
   logic [7:0] sfr_rdata_r;
   logic [7:0] sfr_rdata_nxt;

   always_comb begin
      ctrl_nxt = ctrl_r;
      sfr_rdata_nxt = 8'h00;
      // enables held until software rewrites them
      if (sfr_wr && sfr_addr == PROGRAM_STORE_CONTROL_OFS) begin
         ctrl_nxt = sfr_wdata[EE_BIT:WE_BIT];
      end
      if (sfr_addr == PROGRAM_STORE_CONTROL_OFS) begin
         sfr_rdata_nxt = {6'h00, ctrl_r};
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrl_r <= PROGRAM_STORE_CONTROL_RST[1:0];
         sfr_rdata_r <= 8'h00;
      end else begin
         ctrl_r <= ctrl_nxt;
         sfr_rdata_r <= sfr_rdata_nxt;
      end
   end
   assign sfr_rdata = sfr_rdata_r;

   // sequencer state
   fpec_state_t state_r, state_nxt;
   fpec_op_t op_r, op_nxt;
   logic who_jtag_r, who_jtag_nxt;
   logic lock_sec_r, lock_sec_nxt;
   logic loaded_r, loaded_nxt;
   logic [7:0] lock_rd_r, lock_rd_nxt;
   logic [7:0] lock_we_r, lock_we_nxt;
   logic [7:0] wdata_r, wdata_nxt;
   logic [7:0] old_r, old_nxt;
   logic [TIME_W-1:0] timer_r, timer_nxt;
   logic [15:0] addr_r, addr_nxt;
   logic rd_r, rd_nxt;
   logic [7:0] awdata_r, awdata_nxt;
   fpec_erase_t ekind_r, ekind_nxt;
   logic [7:0] cpu_rdata_r, cpu_rdata_nxt;
   logic [7:0] jtag_rdata_r, jtag_rdata_nxt;
   logic cpu_done_r, cpu_done_nxt;
   logic jtag_done_r, jtag_done_nxt;
   logic jtag_den_r, jtag_den_nxt;

   logic [15:0] req_addr;
   logic a_valid, a_extra, a_lock_sec, a_lock_byte, a_rd_open, a_we_open;
   logic tick;
   logic inhibit;
   logic can_take;
   logic finish;

   assign req_addr = jtag_req ? jtag_addr : cpu_addr;
   // prescale 1111b inhibits write and erase
   assign inhibit = (timing_prescaler_value == PRESCALE_OFF);
   assign can_take = (state_r == FPEC_IDLE) && loaded_r &&
                     !cpu_done_r && !jtag_done_r;
   assign finish = (state_r == FPEC_BUSY) && tick &&
                   (timer_r == TIME_W'(1));

   fpec_addr_check u_check (
      .addr(req_addr),
      .lock_rd(lock_rd_r),
      .lock_we(lock_we_r),
      .valid(a_valid),
      .in_extra(a_extra),
      .in_lock_sector(a_lock_sec),
      .is_lock_byte(a_lock_byte),
      .rd_open(a_rd_open),
      .we_open(a_we_open)
   );

   // interval ticks come from the prescaler
   fpec_tick_gen #(.PW(4)) u_tick (
      .clock(clock),
      .sys_rst(sys_rst),
      .run(state_r == FPEC_BUSY),
      .prescale(timing_prescaler_value),
      .tick(tick)
   );

   always_comb begin
      state_nxt = state_r;
      op_nxt = op_r;
      who_jtag_nxt = who_jtag_r;
      lock_sec_nxt = lock_sec_r;
      loaded_nxt = loaded_r;
      lock_rd_nxt = lock_rd_r;
      lock_we_nxt = lock_we_r;
      wdata_nxt = wdata_r;
      old_nxt = old_r;
      timer_nxt = timer_r;
      addr_nxt = addr_r;
      rd_nxt = 1'b0;
      awdata_nxt = awdata_r;
      ekind_nxt = ekind_r;
      cpu_rdata_nxt = cpu_rdata_r;
      jtag_rdata_nxt = jtag_rdata_r;
      cpu_done_nxt = 1'b0;
      jtag_done_nxt = 1'b0;
      jtag_den_nxt = 1'b0;
      case (state_r)
         FPEC_IDLE: begin
            if (!loaded_r) begin
               addr_nxt = LOCK_WE_ADDR;
               rd_nxt = 1'b1;
               op_nxt = FPEC_OP_LOCK0;
               state_nxt = FPEC_RD_WAIT;
            end else if (can_take && jtag_req) begin
               who_jtag_nxt = 1'b1;
               addr_nxt = jtag_addr;
               wdata_nxt = jtag_wdata;
               lock_sec_nxt = a_lock_sec;
               if (jtag_op == FPEC_JREAD && a_valid && a_rd_open) begin
                  rd_nxt = 1'b1;
                  op_nxt = FPEC_OP_READ;
                  state_nxt = FPEC_RD_WAIT;
               end else if (jtag_op == FPEC_JWRITE && a_valid &&
                            a_we_open && !inhibit) begin
                  rd_nxt = 1'b1;
                  op_nxt = FPEC_OP_PROG;
                  state_nxt = FPEC_RD_WAIT;
               end else if (jtag_op == FPEC_JERASE && a_valid && !inhibit &&
                            (a_lock_byte || a_we_open)) begin
                  // lock byte address starts mass erase
                  op_nxt = FPEC_OP_ERASE;
                  ekind_nxt = a_lock_byte ? FPEC_ER_MASS :
                              (a_extra ? FPEC_ER_EXTRA : FPEC_ER_MAIN);
                  timer_nxt = TIME_W'(ERASE_TICKS);
                  state_nxt = FPEC_BUSY;
               end else begin
                  jtag_done_nxt = 1'b1;
                  jtag_den_nxt = 1'b1;
               end
            end else if (can_take && code_space_read) begin
               // code reads go straight to the array
               who_jtag_nxt = 1'b0;
               addr_nxt = cpu_addr;
               rd_nxt = 1'b1;
               op_nxt = FPEC_OP_READ;
               state_nxt = FPEC_RD_WAIT;
            end else if (can_take && external_move_write) begin
               who_jtag_nxt = 1'b0;
               addr_nxt = cpu_addr;
               wdata_nxt = cpu_wdata;
               lock_sec_nxt = a_lock_sec;
               if (!ctrl_r[WE_BIT] || inhibit || !a_valid) begin
                  cpu_done_nxt = 1'b1;
               end else if (ctrl_r[EE_BIT]) begin
                  // erase mode discards the data byte
                  // lock byte sector is never erased here
                  if (a_lock_sec) begin
                     cpu_done_nxt = 1'b1;
                  end else begin
                     op_nxt = FPEC_OP_ERASE;
                     ekind_nxt = a_extra ? FPEC_ER_EXTRA : FPEC_ER_MAIN;
                     timer_nxt = TIME_W'(ERASE_TICKS);
                     state_nxt = FPEC_BUSY;
                  end
               end else begin
                  rd_nxt = 1'b1;
                  op_nxt = FPEC_OP_PROG;
                  state_nxt = FPEC_RD_WAIT;
               end
            end
         end
         FPEC_RD_WAIT: begin
            case (op_r)
               FPEC_OP_LOCK0: begin
                  lock_we_nxt = arr_rdata;
                  addr_nxt = LOCK_RD_ADDR;
                  rd_nxt = 1'b1;
                  op_nxt = FPEC_OP_LOCK1;
               end
               FPEC_OP_LOCK1: begin
                  lock_rd_nxt = arr_rdata;
                  loaded_nxt = 1'b1;
                  state_nxt = FPEC_IDLE;
               end
               FPEC_OP_PROG: begin
                  // program value never sets a bit
                  old_nxt = arr_rdata;
                  awdata_nxt = arr_rdata & wdata_r;
                  timer_nxt = TIME_W'(WRITE_TICKS);
                  state_nxt = FPEC_BUSY;
               end
               default: begin
                  if (who_jtag_r) begin
                     jtag_rdata_nxt = arr_rdata;
                     jtag_done_nxt = 1'b1;
                  end else begin
                     cpu_rdata_nxt = arr_rdata;
                     cpu_done_nxt = 1'b1;
                  end
                  state_nxt = FPEC_IDLE;
               end
            endcase
         end
         FPEC_BUSY: begin
            if (tick) begin
               timer_nxt = timer_r - TIME_W'(1);
            end
            if (finish) begin
               state_nxt = FPEC_IDLE;
               jtag_done_nxt = who_jtag_r;
               cpu_done_nxt = !who_jtag_r;
               if (op_r == FPEC_OP_PROG && addr_r == LOCK_WE_ADDR) begin
                  lock_we_nxt = lock_we_r & awdata_r;
               end
               if (op_r == FPEC_OP_PROG && addr_r == LOCK_RD_ADDR) begin
                  lock_rd_nxt = lock_rd_r & awdata_r;
               end
               if (op_r == FPEC_OP_ERASE &&
                   (ekind_r == FPEC_ER_MASS || lock_sec_r)) begin
                  lock_we_nxt = ERASED_BYTE;
                  lock_rd_nxt = ERASED_BYTE;
               end
            end
         end
         default: begin
            state_nxt = FPEC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_r <= FPEC_IDLE;
         op_r <= FPEC_OP_READ;
         who_jtag_r <= 1'b0;
         lock_sec_r <= 1'b0;
         loaded_r <= 1'b0;
         lock_rd_r <= 8'h00;
         lock_we_r <= 8'h00;
         wdata_r <= 8'h00;
         old_r <= 8'h00;
         timer_r <= '0;
         addr_r <= 16'h0000;
         rd_r <= 1'b0;
         awdata_r <= 8'h00;
         ekind_r <= FPEC_ER_MAIN;
         cpu_rdata_r <= 8'h00;
         jtag_rdata_r <= 8'h00;
         cpu_done_r <= 1'b0;
         jtag_done_r <= 1'b0;
         jtag_den_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         op_r <= op_nxt;
         who_jtag_r <= who_jtag_nxt;
         lock_sec_r <= lock_sec_nxt;
         loaded_r <= loaded_nxt;
         lock_rd_r <= lock_rd_nxt;
         lock_we_r <= lock_we_nxt;
         wdata_r <= wdata_nxt;
         old_r <= old_nxt;
         timer_r <= timer_nxt;
         addr_r <= addr_nxt;
         rd_r <= rd_nxt;
         awdata_r <= awdata_nxt;
         ekind_r <= ekind_nxt;
         cpu_rdata_r <= cpu_rdata_nxt;
         jtag_rdata_r <= jtag_rdata_nxt;
         cpu_done_r <= cpu_done_nxt;
         jtag_done_r <= jtag_done_nxt;
         jtag_den_r <= jtag_den_nxt;
      end
   end

   assign arr_addr = addr_r;
   assign arr_rd = rd_r;
   assign arr_wdata = awdata_r;
   assign arr_prog = (state_r == FPEC_BUSY) && (op_r == FPEC_OP_PROG);
   assign arr_erase = (state_r == FPEC_BUSY) && (op_r == FPEC_OP_ERASE);
   assign arr_erase_kind = ekind_r;
   assign cpu_rdata = cpu_rdata_r;
   assign cpu_done = cpu_done_r;
   assign jtag_rdata = jtag_rdata_r;
   assign jtag_done = jtag_done_r;
   assign jtag_denied = jtag_den_r;
   // core held while a request waits or array is busy
   assign cpu_stall = ((external_move_write || code_space_read) &&
                       !cpu_done_r) || (state_r == FPEC_BUSY);

   sequence s_refuse_now;
      jtag_done_r && jtag_den_r;
   endsequence

   a_stall_busy: assert property (@(posedge clock) disable iff (sys_rst)
      (arr_prog || arr_erase) |-> cpu_stall)
      else $error("core not stalled during array operation");
   a_inhibit_start: assert property (@(posedge clock) disable iff (sys_rst)
      $rose(state_r == FPEC_BUSY) |-> $past(timing_prescaler_value) != 4'hF)
      else $error("operation started while prescaler inhibits");
   a_sw_write_gate: assert property (@(posedge clock) disable iff (sys_rst)
      (arr_prog && !who_jtag_r) |-> ctrl_r[WE_BIT])
      else $error("software program without write enable");
   a_prog_clears: assert property (@(posedge clock) disable iff (sys_rst)
      arr_prog |-> ((arr_wdata & ~old_r) == 8'h00))
      else $error("program value sets a bit");
   a_sw_erase_mode: assert property (@(posedge clock) disable iff (sys_rst)
      (arr_erase && !who_jtag_r) |-> (ctrl_r == 2'h3 && !lock_sec_r))
      else $error("software erase without both enables or on lock sector");
   a_timed_end: assert property (@(posedge clock) disable iff (sys_rst)
      finish |=> (state_r == FPEC_IDLE) && (cpu_done_r || jtag_done_r))
      else $error("operation end not reported next cycle");
   a_mass_unlock: assert property (@(posedge clock) disable iff (sys_rst)
      (finish && arr_erase && ekind_r == FPEC_ER_MASS) |=>
      (lock_rd_r == 8'hFF && lock_we_r == 8'hFF))
      else $error("mass erase left lock bits cleared");
   a_jtag_rd_lock: assert property (@(posedge clock) disable iff (sys_rst)
      (can_take && jtag_req && jtag_op == FPEC_JREAD && !a_rd_open) |=>
      s_refuse_now)
      else $error("locked jtag read not refused");
   a_jtag_wr_lock: assert property (@(posedge clock) disable iff (sys_rst)
      (can_take && jtag_req && jtag_op == FPEC_JWRITE && !a_we_open) |=>
      s_refuse_now ##1 (state_r == FPEC_IDLE))
      else $error("locked jtag write not refused");
   a_ctrl_upper: assert property (@(posedge clock) disable iff (sys_rst)
      sfr_rdata[7:2] == 6'h00)
      else $error("unused control bits read nonzero");
endmodule
`default_nettype wire

//--- testbench/fpec_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module fpec_flash_model (
   // array port
   input wire logic clock,
   input wire logic [15:0] arr_addr,
   input wire logic arr_rd,
   output logic [7:0] arr_rdata,
   input wire logic [7:0] arr_wdata,
   input wire logic arr_prog,
   input wire logic arr_erase,
   input wire fpec_pkg::fpec_erase_t arr_erase_kind
);
   import fpec_pkg::*;
   logic [7:0] mem [0:32895];
   logic [7:0] last_r = 8'h00;
   int base;
   initial begin
      for (int i = 0; i < 32896; i++) mem[i] = ERASED_BYTE;
   end
   // data stands in the cycle that arr_rd is high
   // idle bus shows the inverse of the last byte read
   assign arr_rdata = arr_rd ? mem[arr_addr] : ~last_r;
   always @(posedge clock) begin
      if (arr_rd) last_r <= mem[arr_addr];
      if (arr_prog) mem[arr_addr] = arr_wdata;
      if (arr_erase) begin
         case (arr_erase_kind)
            FPEC_ER_MAIN: begin
               base = {arr_addr[15:9], 9'h000};
               for (int i = 0; i < 512; i++) mem[base + i] = ERASED_BYTE;
            end
            FPEC_ER_EXTRA: begin
               for (int i = 0; i < 128; i++) mem[32768 + i] = ERASED_BYTE;
            end
            default: begin
               for (int i = 0; i < 32768; i++) mem[i] = ERASED_BYTE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import fpec_pkg::*;
   localparam int WT = 4;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
   logic sfr_wr = 1'b0;
   logic [3:0] presc = 4'h0;
   logic mwr = 1'b0, crd = 1'b0, cpu_done, cpu_stall;
   logic [15:0] cpu_addr = 16'h0000, jtag_addr = 16'h0000, arr_addr;
   logic [7:0] cpu_wdata = 8'h00, cpu_rdata, jtag_wdata = 8'h00, jtag_rdata;
   logic jtag_req = 1'b0, jtag_done, jtag_denied;
   fpec_jop_t jtag_op = FPEC_JREAD;
   logic arr_rd, arr_prog, arr_erase;
   logic [7:0] arr_rdata, arr_wdata;
   fpec_erase_t kind;
   int errors = 0, samples_checked = 0, st;
   logic [7:0] q;
   logic den;

   always #2 clock = ~clock;

   fpec_top #(.WRITE_TICKS(WT), .ERASE_TICKS(8)) i_dut (.clock(clock),
      .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .timing_prescaler_value(presc), .external_move_write(mwr),
      .code_space_read(crd), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
      .cpu_rdata(cpu_rdata), .cpu_done(cpu_done), .cpu_stall(cpu_stall),
      .jtag_req(jtag_req), .jtag_op(jtag_op), .jtag_addr(jtag_addr),
      .jtag_wdata(jtag_wdata), .jtag_rdata(jtag_rdata),
      .jtag_done(jtag_done), .jtag_denied(jtag_denied),
      .arr_addr(arr_addr), .arr_rd(arr_rd), .arr_rdata(arr_rdata),
      .arr_wdata(arr_wdata), .arr_prog(arr_prog), .arr_erase(arr_erase),
      .arr_erase_kind(kind));

   fpec_flash_model i_flash (.clock(clock), .arr_addr(arr_addr),
      .arr_rd(arr_rd), .arr_rdata(arr_rdata), .arr_wdata(arr_wdata),
      .arr_prog(arr_prog), .arr_erase(arr_erase), .arr_erase_kind(kind));

   task automatic stop_test();
      if (errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic sfr_set(input logic [7:0] d);
      @(posedge clock);
      sfr_addr <= PROGRAM_STORE_CONTROL_OFS;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clock);
      sfr_wr <= 1'b0;
   endtask

   task automatic sfr_get(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      sfr_addr <= a;
      repeat (2) @(posedge clock);
      #1 check(sfr_rdata, exp);
   endtask

   // one processor access; stall cycles counted while waiting
   task automatic cpu(input logic wr, input logic [15:0] a,
                      input logic [7:0] d);
      int n;
      n = 0;
      st = 0;
      @(posedge clock);
      cpu_addr <= a;
      cpu_wdata <= d;
      if (wr) mwr <= 1'b1;
      else crd <= 1'b1;
      do begin
         @(posedge clock);
         #1;
         if (cpu_stall === 1'b1) st++;
         n++;
      end while (cpu_done !== 1'b1 && n < 2000);
      if (cpu_done !== 1'b1) begin
         errors++;
         stop_test();
      end
      q = cpu_rdata;
      @(posedge clock);
      mwr <= 1'b0;
      crd <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      cpu(1'b0, a, 8'h00);
      check(q, exp);
   endtask

   task automatic jtag(input fpec_jop_t op, input logic [15:0] a,
                       input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clock);
      jtag_op <= op;
      jtag_addr <= a;
      jtag_wdata <= d;
      jtag_req <= 1'b1;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (jtag_done !== 1'b1 && n < 2000);
      if (jtag_done !== 1'b1) begin
         errors++;
         stop_test();
      end
      q = jtag_rdata;
      den = jtag_denied;
      @(posedge clock);
      jtag_req <= 1'b0;
   endtask

   initial begin
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clock);
      sfr_get(PROGRAM_STORE_CONTROL_OFS, 8'h00);
      sfr_set(8'hFF);
      sfr_get(PROGRAM_STORE_CONTROL_OFS, 8'h03);
      sfr_get(8'h8E, 8'h00);
      sfr_set(8'h00);
      jtag(FPEC_JWRITE, 16'h0200, 8'h3C);
      check(den, 1'b0);
      rd(16'h0200, 8'h3C);
      cpu(1'b1, 16'h0010, 8'hA5);
      rd(16'h0010, 8'hFF);
      sfr_set(8'h01);
      cpu(1'b1, 16'h0010, 8'h5A);
      check(st >= WT, 1'b1);
      rd(16'h0010, 8'h5A);
      cpu(1'b1, 16'h0010, 8'hF0);
      rd(16'h0010, 8'h50);
      presc <= PRESCALE_OFF;
      cpu(1'b1, 16'h0011, 8'h00);
      presc <= 4'h0;
      rd(16'h0011, 8'hFF);
      presc <= 4'h1;
      cpu(1'b1, 16'h0012, 8'h0F);
      presc <= 4'h0;
      check(st >= 2 * WT, 1'b1);
      rd(16'h0012, 8'h0F);
      // erase enable, write enable, one sector write
      sfr_set(8'h03);
      cpu(1'b1, 16'h0000, 8'h00);
      rd(16'h0010, 8'hFF);
      rd(16'h01FF, 8'hFF);
      rd(16'h0200, 8'h3C);
      cpu(1'b1, 16'h0200, 8'h00);
      rd(16'h0200, 8'hFF);
      sfr_set(8'h01);
      cpu(1'b1, 16'h8005, 8'h12);
      rd(16'h8005, 8'h12);
      cpu(1'b1, 16'h7C00, 8'h77);
      sfr_set(8'h03);
      cpu(1'b1, 16'h8000, 8'h00);
      rd(16'h8005, 8'hFF);
      cpu(1'b1, 16'h7C00, 8'h00);
      rd(16'h7C00, 8'h77);
      sfr_set(8'h01);
      cpu(1'b1, LOCK_WE_ADDR, 8'hFE);
      cpu(1'b1, LOCK_RD_ADDR, 8'hFD);
      sfr_set(8'h00);
      jtag(FPEC_JWRITE, 16'h0100, 8'h00);
      check(den, 1'b1);
      jtag(FPEC_JWRITE, 16'h1000, 8'h0F);
      check(den, 1'b0);
      jtag(FPEC_JREAD, 16'h1000, 8'h00);
      check(den, 1'b1);
      jtag(FPEC_JREAD, 16'h0200, 8'h00);
      check({den, q}, 9'h0FF);
      jtag(FPEC_JERASE, 16'h0100, 8'h00);
      check(den, 1'b1);
      jtag(FPEC_JERASE, LOCK_RD_ADDR, 8'h00);
      jtag(FPEC_JREAD, 16'h1000, 8'h00);
      check({den, q}, 9'h0FF);
      sfr_set(8'h01);
      cpu(1'b1, LOCK_RD_ADDR, 8'h00);
      jtag(FPEC_JREAD, 16'h1000, 8'h00);
      check(den, 1'b1);
      jtag(FPEC_JERASE, 16'h7C00, 8'h00);
      jtag(FPEC_JREAD, 16'h1000, 8'h00);
      check(den, 1'b0);
      stop_test();
   end
endmodule
`default_nettype wire
